// ===== include/vtf_defines.vh
// Constants for the blanking-line, timing and freeze control block
`ifndef VTF_DEFINES_VH
`define VTF_DEFINES_VH

// Sizes
`define VTF_NCH          4
`define VTF_NPRESET      5
`define VTF_CFG_W        48
`define VTF_BUF_AW       15

// Register offsets (byte addresses)
`define VTF_ADDR_CTRL    8'h00
`define VTF_ADDR_STATUS  8'h04
`define VTF_ADDR_CH_BASE 8'h10
`define VTF_CH_STRIDE    8'h08
`define VTF_ADDR_CH_END  8'h30

// Control register fields
`define VTF_CTRL_SLOT_LSB 0
`define VTF_CTRL_LEARN    4
`define VTF_CTRL_RECALL   5
`define VTF_CTRL_FACTORY  6

// Status register fields
`define VTF_STAT_LOSS_LSB    0
`define VTF_STAT_FS          4
`define VTF_STAT_SLOT_LSB    8
`define VTF_STAT_RECALLED    11
`define VTF_STAT_LEARNED_LSB 12

// Channel word A fields (cfg bits 23:0)
`define VTF_F_NOTCH      0
`define VTF_F_VBI_CKILL  1
`define VTF_F_CKILL      2
`define VTF_F_SETUP_AV   3
`define VTF_F_ENH_LSB    4
`define VTF_F_FRZ_LSB    8
`define VTF_F_VOFF_LSB   12
`define VTF_F_HOFF_LSB   16
// Channel word B fields (cfg bits 47:24)
`define VTF_F_SETUP_MASK 24
`define VTF_F_BLANK_MASK 32
`define VTF_F_DATA_MASK  40

// Writable bits and reset values of the channel words
`define VTF_CFGA_MASK    24'hFFF73F
`define VTF_CFGB_MASK    24'hFFFFFF
`define VTF_CFGA_RST     24'h000000
`define VTF_CFGB_RST     24'h000000

// Freeze modes
`define VTF_FRZ_NONE     3'h0
`define VTF_FRZ_HOLD     3'h1
`define VTF_FRZ_BLUE     3'h2
`define VTF_FRZ_FLD1     3'h3
`define VTF_FRZ_FLD2     3'h4
`define VTF_FRZ_FRAME    3'h5

// Enhancement levels
`define VTF_ENH_OFF      2'h0
`define VTF_ENH_LOW      2'h1
`define VTF_ENH_MED      2'h2

// Video levels
`define VTF_BLACK_Y      10'h040
`define VTF_CHROMA_ZERO  10'h200
`define VTF_SETUP_Y      10'h02C
`define VTF_Y_LO         12'h004
`define VTF_Y_HI         12'h3FB
`define VTF_BLUE_Y       10'h0A6
`define VTF_BLUE_CB      10'h3C0
`define VTF_BLUE_CR      10'h1DC
`define VTF_LINE_SAMPLES 15'h06B4

// Timing
`define VTF_CLK_MHZ      40
`define VTF_LOSS_TIME_US 40000
`define VTF_LOSS_CYCLES  (`VTF_LOSS_TIME_US * `VTF_CLK_MHZ)

`endif

// ===== rtl/vtf_field_store.v
// Field store with output delay, freeze hold and blue-screen insertion
`timescale 1ns/1ps
`include "vtf_defines.vh"

module vtf_field_store (
	// Clock and reset
	input  wire        clk,
	input  wire        resetn,
	// Processed stream in, bit 10 marks chroma
	input  wire [10:0] wr_data,
	// Control
	input  wire        hold,
	input  wire        blue,
	input  wire [14:0] delay,
	// Delayed stream out
	output reg  [9:0]  out_data_reg,
	output reg         out_chroma_reg
);

	reg [10:0] mem [0:(1<<`VTF_BUF_AW)-1];
	reg [14:0] wr_ptr_reg;
	reg [14:0] rd_ptr_reg;
	reg [10:0] q_reg;
	reg        cb_phase_reg;

	// Writes stop while held so the stored field repeats
	always @(posedge clk) begin
		if (!hold) begin
			mem[wr_ptr_reg] <= wr_data;
		end
		q_reg <= mem[rd_ptr_reg];
	end

	always @(posedge clk) begin
		if (!resetn) begin
			wr_ptr_reg     <= 15'h0000;
			rd_ptr_reg     <= 15'h0000;
			cb_phase_reg   <= 1'b0;
			out_data_reg   <= `VTF_BLACK_Y;
			out_chroma_reg <= 1'b0;
		end else begin
			if (!hold) begin
				wr_ptr_reg <= wr_ptr_reg + 15'h0001;
				rd_ptr_reg <= wr_ptr_reg - delay;
			end else begin
				rd_ptr_reg <= rd_ptr_reg + 15'h0001;
			end
			if (q_reg[10]) begin
				cb_phase_reg <= ~cb_phase_reg;
			end
			out_chroma_reg <= q_reg[10];
			if (blue) begin
				if (!q_reg[10]) begin
					out_data_reg <= `VTF_BLUE_Y;
				end else if (!cb_phase_reg) begin
					out_data_reg <= `VTF_BLUE_CB;
				end else begin
					out_data_reg <= `VTF_BLUE_CR;
				end
			end else begin
				out_data_reg <= q_reg[9:0];
			end
		end
	end

endmodule

// ===== rtl/vtf_ctrl.v
// Four-channel blanking-line, timing, freeze and preset control
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ps
`include "vtf_defines.vh"

module vtf_ctrl #(
	parameter LOSS_CYCLES = `VTF_LOSS_CYCLES
) (
	// Clock and reset
	input  wire        clk,
	input  wire        resetn,
	// Register port
	input  wire [7:0]  reg_addr,
	input  wire [31:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [31:0] reg_rdata,
	// Frame sync option strap
	input  wire        fs_option_pin,
	// Decoded streams, one slice per channel
	input  wire [39:0] vid_in,
	input  wire [3:0]  vid_chroma,
	input  wire [3:0]  vid_field_start,
	input  wire [3:0]  vid_field2,
	input  wire [3:0]  vid_vbi,
	input  wire [11:0] vid_pair,
	input  wire [3:0]  line_525,
	// Output streams
	output wire [39:0] vid_out,
	output wire [3:0]  vid_out_chroma,
	output reg  [3:0]  loss_out
);

	localparam CW = `VTF_CFG_W;
	localparam AW = CW * `VTF_NCH;
	localparam [11:0] Y_LO = `VTF_Y_LO;
	localparam [11:0] Y_HI = `VTF_Y_HI;

	reg  [2:0]    fs_sync_reg;
	reg           fs_option_reg;
	reg  [AW-1:0] cfg_reg;
	reg  [AW-1:0] preset_mem [0:`VTF_NPRESET-1];
	reg  [4:0]    learned_reg;
	reg  [2:0]    last_slot_reg;
	reg           recalled_reg;
	reg  [31:0]   rd_next;
	wire [AW-1:0] cfg_default;
	wire          ctrl_wr;
	wire [2:0]    slot;
	wire          slot_ok;
	wire          do_learn;
	wire          do_recall;
	wire          do_factory;
	wire [3:0]    loss_next;
	integer       i;
	integer       j;

	assign cfg_default = {`VTF_NCH{`VTF_CFGB_RST, `VTF_CFGA_RST}};
	assign ctrl_wr     = reg_wr && (reg_addr == `VTF_ADDR_CTRL);
	assign slot        = reg_wdata[`VTF_CTRL_SLOT_LSB +: 3];
	assign slot_ok     = (slot < 3'h5);
	assign do_factory  = ctrl_wr && reg_wdata[`VTF_CTRL_FACTORY];
	assign do_recall   = ctrl_wr && reg_wdata[`VTF_CTRL_RECALL] && slot_ok &&
		learned_reg[slot];
	assign do_learn    = ctrl_wr && reg_wdata[`VTF_CTRL_LEARN] && slot_ok;

	// Strap passes three flops; a change counts once the last two agree
	always @(posedge clk) begin
		fs_sync_reg <= {fs_sync_reg[1:0], fs_option_pin};
		if (!resetn) begin
			fs_option_reg <= 1'b0;
		end else if (fs_sync_reg[2] == fs_sync_reg[1]) begin
			fs_option_reg <= fs_sync_reg[2];
		end
	end

	// Settings, preset learn and recall
	always @(posedge clk) begin
		if (!resetn) begin
			cfg_reg       <= cfg_default;
			learned_reg   <= 5'h00;
			last_slot_reg <= 3'h0;
			recalled_reg  <= 1'b0;
		end else if (do_factory) begin
			cfg_reg      <= cfg_default;
			recalled_reg <= 1'b0;
		end else if (do_recall) begin
			cfg_reg       <= preset_mem[slot];
			last_slot_reg <= slot;
			recalled_reg  <= 1'b1;
		end else if (reg_wr) begin
			for (i = 0; i < `VTF_NCH; i = i + 1) begin
				if (reg_addr == `VTF_ADDR_CH_BASE + i * `VTF_CH_STRIDE) begin
					cfg_reg[i*CW +: 24] <= reg_wdata[23:0] & `VTF_CFGA_MASK;
				end else if (reg_addr ==
					`VTF_ADDR_CH_BASE + i * `VTF_CH_STRIDE + 4) begin
					cfg_reg[i*CW+24 +: 24] <= reg_wdata[23:0] &
						`VTF_CFGB_MASK;
				end
			end
		end
		if (resetn && do_learn && !do_factory && !do_recall) begin
			learned_reg[slot] <= 1'b1;
		end
	end

	// Whole configuration captured into one slot
	always @(posedge clk) begin
		if (resetn && do_learn && !do_factory && !do_recall) begin
			preset_mem[slot] <= cfg_reg;
		end
	end

	// Read decode
	always @* begin
		rd_next = 32'h00000000;
		if (reg_addr == `VTF_ADDR_CTRL) begin
			rd_next = 32'h00000000;
		end else if (reg_addr == `VTF_ADDR_STATUS) begin
			rd_next[`VTF_STAT_LOSS_LSB +: 4]    = loss_out;
			rd_next[`VTF_STAT_FS]               = fs_option_reg;
			rd_next[`VTF_STAT_SLOT_LSB +: 3]    = last_slot_reg;
			rd_next[`VTF_STAT_RECALLED]         = recalled_reg;
			rd_next[`VTF_STAT_LEARNED_LSB +: 5] = learned_reg;
		end else begin
			for (j = 0; j < `VTF_NCH; j = j + 1) begin
				if (reg_addr == `VTF_ADDR_CH_BASE + j * `VTF_CH_STRIDE) begin
					rd_next[23:0] = cfg_reg[j*CW +: 24];
				end else if (reg_addr ==
					`VTF_ADDR_CH_BASE + j * `VTF_CH_STRIDE + 4) begin
					rd_next[23:0] = cfg_reg[j*CW+24 +: 24];
				end
			end
		end
	end

	always @(posedge clk) begin
		if (!resetn) begin
			reg_rdata <= 32'h00000000;
		end else begin
			reg_rdata <= reg_rd ? rd_next : 32'h00000000;
		end
	end

	// Loss flags of all channels kept in one register
	always @(posedge clk) begin
		if (!resetn) begin
			loss_out <= 4'hF;
		end else begin
			loss_out <= loss_next;
		end
	end

	genvar g;
	generate
		for (g = 0; g < `VTF_NCH; g = g + 1) begin : ch
			reg  [CW-1:0]      act_reg;
			reg  [20:0]        sync_cnt_reg;
			reg                man_hold_reg;
			reg  [9:0]         y_prev_reg;
			reg  [10:0]        s1_reg;
			reg  [10:0]        y0;
			reg  [11:0]        y1;
			reg  signed [11:0] diff;
			reg  signed [11:0] e;
			reg  [9:0]         d;
			wire [9:0]         x;
			wire               c;
			wire [2:0]         pair;
			wire [1:0]         enh;
			wire [2:0]         mode;
			wire [3:0]         voff;
			wire [7:0]         hoff;
			wire               is_vbi;
			wire               is_data;
			wire               do_blank;
			wire               do_setup;
			wire               do_kill;
			wire               do_notch;
			wire               loss;
			wire               hold;
			wire               blue;
			wire [14:0]        delay;

			assign x        = vid_in[g*10 +: 10];
			assign c        = vid_chroma[g];
			assign pair     = vid_pair[g*3 +: 3];
			assign enh      = act_reg[`VTF_F_ENH_LSB +: 2];
			assign voff     = act_reg[`VTF_F_VOFF_LSB +: 4];
			assign hoff     = act_reg[`VTF_F_HOFF_LSB +: 8];
			assign mode     = fs_option_reg ?
				act_reg[`VTF_F_FRZ_LSB +: 3] : `VTF_FRZ_NONE;
			assign is_vbi   = vid_vbi[g];
			assign is_data  = is_vbi &
				act_reg[`VTF_F_DATA_MASK + pair];
			assign do_blank = is_vbi & ~is_data &
				act_reg[`VTF_F_BLANK_MASK + pair];
			assign do_setup = is_vbi & ~is_data & line_525[g] &
				act_reg[`VTF_F_SETUP_AV] &
				act_reg[`VTF_F_SETUP_MASK + pair];
			// Or-ing the two kills: the full kill covers every line, the blanking kill only VBI lines not kept for data
			assign do_kill  = act_reg[`VTF_F_CKILL] |
				(is_vbi & ~is_data & act_reg[`VTF_F_VBI_CKILL]);
			assign do_notch = is_vbi & act_reg[`VTF_F_NOTCH];
			assign loss     = loss_out[g];
			assign hold     = man_hold_reg |
				(mode == `VTF_FRZ_HOLD && loss);
			assign blue     = (mode == `VTF_FRZ_BLUE) && loss;
			assign delay    = fs_option_reg ?
				({11'h000, voff} * `VTF_LINE_SAMPLES) + {7'h00, hoff} :
				{7'h00, hoff};

			// Pending settings take effect at a field start or while lost
			always @(posedge clk) begin
				if (!resetn) begin
					act_reg <= cfg_default[g*CW +: CW];
				end else if (vid_field_start[g] || loss) begin
					act_reg <= cfg_reg[g*CW +: CW];
				end
			end

			// Loss when no field start arrives for the timeout
			always @(posedge clk) begin
				if (!resetn || vid_field_start[g]) begin
					sync_cnt_reg <= 21'h000000;
				end else if (sync_cnt_reg < LOSS_CYCLES - 1) begin
					sync_cnt_reg <= sync_cnt_reg + 21'h000001;
				end
			end
			assign loss_next[g] = vid_field_start[g] ? 1'b0 :
				(sync_cnt_reg >= LOSS_CYCLES - 1) ? 1'b1 : loss_out[g];

			// Manual freeze latches at the end of the chosen field
			always @(posedge clk) begin
				if (!resetn) begin
					man_hold_reg <= 1'b0;
				end else if (mode == `VTF_FRZ_FLD1 ||
					mode == `VTF_FRZ_FLD2 || mode == `VTF_FRZ_FRAME) begin
					if (vid_field_start[g] &&
						((mode == `VTF_FRZ_FLD1 && vid_field2[g]) ||
						(mode != `VTF_FRZ_FLD1 && !vid_field2[g]))) begin
						man_hold_reg <= 1'b1;
					end
				end else begin
					man_hold_reg <= 1'b0;
				end
			end

			// Sample processing
			always @* begin
				y0 = {1'b0, x};
				if (do_notch) begin
					y0 = ({1'b0, x} + {1'b0, y_prev_reg}) >> 1;
				end
				y1 = {1'b0, y0};
				if (do_setup) begin
					y1 = (y0 > {1'b0, `VTF_BLACK_Y + `VTF_SETUP_Y}) ?
						{1'b0, y0} - {2'b00, `VTF_SETUP_Y} :
						{2'b00, `VTF_BLACK_Y};
				end
				diff = $signed(y1) - $signed({2'b00, y_prev_reg});
				e = $signed(y1);
				if (!is_vbi && enh != `VTF_ENH_OFF) begin
					if (enh == `VTF_ENH_LOW) begin
						e = $signed(y1) + (diff >>> 3);
					end else if (enh == `VTF_ENH_MED) begin
						e = $signed(y1) + (diff >>> 2);
					end else begin
						e = $signed(y1) + (diff >>> 1);
					end
				end
				if (e < $signed(Y_LO)) begin
					d = Y_LO[9:0];
				end else if (e > $signed(Y_HI)) begin
					d = Y_HI[9:0];
				end else begin
					d = e[9:0];
				end
				if (c) begin
					d = do_kill ? `VTF_CHROMA_ZERO : x;
				end
				if (do_blank) begin
					d = c ? `VTF_CHROMA_ZERO : `VTF_BLACK_Y;
				end
			end

			always @(posedge clk) begin
				if (!resetn) begin
					y_prev_reg <= `VTF_BLACK_Y;
					s1_reg     <= {1'b0, `VTF_BLACK_Y};
				end else begin
					if (!c) begin
						y_prev_reg <= x;
					end
					s1_reg <= {c, d};
				end
			end

			vtf_field_store store (
				.clk            (clk),
				.resetn         (resetn),
				.wr_data        (s1_reg),
				.hold           (hold),
				.blue           (blue),
				.delay          (delay),
				.out_data_reg   (vid_out[g*10 +: 10]),
				.out_chroma_reg (vid_out_chroma[g])
			);
		end
	endgenerate

endmodule

// ===== verif/vtf_ctrl_assertions.sv
// Port-level assertions for the control block
`timescale 1ns/1ps
module vtf_ctrl_assertions #(
	parameter LOSS_CYCLES = 64
) (
	// Clock and reset
	input wire        clk,
	input wire        resetn,
	// Register port
	input wire [7:0]  reg_addr,
	input wire        reg_rd,
	input wire [31:0] reg_rdata,
	// Stream status
	input wire [3:0]  vid_field_start,
	input wire [3:0]  loss_out
);
	reg [31:0] gap_reg;

	// Cycles since the last field start on channel 0
	always @(posedge clk) begin
		if (!resetn || vid_field_start[0])
			gap_reg <= 32'h00000000;
		else
			gap_reg <= gap_reg + 32'h00000001;
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	sequence rd_s(logic [7:0] a);
		$past(reg_rd) && $past(reg_addr) == a;
	endsequence

	rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data not zero outside answer cycle");
	ctrl_wo_a: assert property (rd_s(8'h00) |-> reg_rdata == 32'h0)
		else $error("control word read back nonzero");
	unmap_rd_a: assert property ($past(reg_rd) &&
		($past(reg_addr) >= 8'h30 || $past(reg_addr[1:0]) != 2'h0)
		|-> reg_rdata == 32'h0) else $error("unmapped read nonzero");
	cfg_rsv_a: assert property ($past(reg_rd) && $past(reg_addr) >= 8'h10
		&& $past(reg_addr) < 8'h30 |-> (reg_rdata & ($past(reg_addr[2])
		? 32'hFF000000 : 32'hFF0008C0)) == 32'h0)
		else $error("reserved channel bits nonzero");
	stat_loss_a: assert property (rd_s(8'h04) ##0 $stable(loss_out)
		|-> reg_rdata[3:0] == loss_out) else $error("status loss mismatch");
	stat_rsv_a: assert property (rd_s(8'h04) |-> reg_rdata[31:17] == 15'h0
		&& reg_rdata[7:5] == 3'h0) else $error("status spare bits set");
	loss_rise_a: assert property (gap_reg == LOSS_CYCLES + 2
		|-> loss_out[0]) else $error("loss not flagged");
	loss_clr_a: assert property (vid_field_start[0] |-> ##[1:2] !loss_out[0])
		else $error("loss not cleared by field start");
	loss_fall_a: assert property ($fell(loss_out[0]) |->
		$past(vid_field_start[0]) || $past(vid_field_start[0], 2))
		else $error("loss cleared without field start");
endmodule

bind vtf_ctrl vtf_ctrl_assertions #(.LOSS_CYCLES(LOSS_CYCLES))
	chk_u (.*);

// ===== verif/vtf_video_src.sv
// Decoded video source feeding all four channels
`timescale 1ns/1ps
module vtf_video_src #(
	parameter FLD = 40
) (
	input  wire        clk,
	input  wire        resetn,
	input  wire [3:0]  run,
	output reg  [39:0] vid_in,
	output reg  [3:0]  vid_chroma,
	output reg  [3:0]  vid_field_start,
	output reg  [3:0]  vid_field2,
	output wire [3:0]  vid_vbi,
	output wire [11:0] vid_pair,
	output wire [3:0]  line_525
);
	reg [7:0] pos_reg;
	reg       fld2_reg;
	integer   n;

	initial {vid_in, vid_chroma, vid_field_start, vid_field2} = 52'h0;
	assign vid_vbi = {4{pos_reg < 8'h10}};
	assign vid_pair = {4{pos_reg[3:1]}};
	assign line_525 = 4'hF;

	always @(posedge clk) begin
		if (!resetn || pos_reg == FLD - 1)
			pos_reg <= 8'h00;
		else
			pos_reg <= pos_reg + 8'h01;
		if (!resetn)
			fld2_reg <= 1'b0;
		else if (pos_reg == FLD - 1)
			fld2_reg <= ~fld2_reg;
		for (n = 0; n < 4; n = n + 1) begin
			vid_chroma[n] <= pos_reg[0];
			vid_field_start[n] <= run[n] && pos_reg == FLD - 1;
			vid_field2[n] <= fld2_reg ^ (pos_reg == FLD - 1);
			// A lost input shows a pattern that moves every cycle
			vid_in[10*n +: 10] <= run[n] ?
				(pos_reg[0] ? 10'h300 : 10'h180) : {5{pos_reg[1:0]}};
		end
	end
endmodule

// ===== verif/vtf_ctrl_test.sv
// Self-checking bench for the control block
`timescale 1ns/1ps
`include "vtf_defines.vh"
module vtf_ctrl_test;
	localparam LOSS = 64;
	reg         clk;
	reg         resetn;
	reg  [7:0]  reg_addr;
	reg  [31:0] reg_wdata;
	reg         reg_wr;
	reg         reg_rd;
	reg         fs_option_pin;
	reg  [3:0]  run;
	reg  [1:0]  mon;
	wire [31:0] reg_rdata;
	wire [39:0] vid_in;
	wire [3:0]  vid_chroma;
	wire [3:0]  vid_field_start;
	wire [3:0]  vid_field2;
	wire [3:0]  vid_vbi;
	wire [11:0] vid_pair;
	wire [3:0]  line_525;
	wire [39:0] vid_out;
	wire [3:0]  vid_out_chroma;
	wire [3:0]  loss_out;
	integer     miscompares;
	integer     checks;
	integer     cyc;
	integer     blk;
	integer     n;

	vtf_ctrl #(.LOSS_CYCLES(LOSS)) dut_u (.*);
	vtf_video_src src_u (.*);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task chk(input [31:0] got, input [31:0] exp);
		checks = checks + 1;
		if (got !== exp) begin
			miscompares = miscompares + 1;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task summarize;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task wr(input [7:0] a, input [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task rd(input [7:0] a, input [31:0] m, input [31:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata & m, e);
	endtask

	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			miscompares = miscompares + 1;
			summarize;
		end
	end

	// Output watch on channel 0 while a video scenario runs
	always @(negedge clk) begin
		if (mon == 2'h1 && vid_out_chroma[0])
			chk(vid_out[9:0], `VTF_CHROMA_ZERO);
		if (mon == 2'h2 && !vid_out_chroma[0])
			chk(vid_out[9:0], `VTF_BLUE_Y);
		// Blanked luma samples seen over one field
		if (mon == 2'h3 && !vid_out_chroma[0] &&
			vid_out[9:0] == `VTF_BLACK_Y)
			blk = blk + 1;
	end

	initial begin
		{reg_addr, reg_wdata, reg_wr, reg_rd, mon} = 44'h0;
		{miscompares, checks, cyc, blk} = 0;
		resetn = 1'b0;
		fs_option_pin = 1'b1;
		run = 4'hF;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		for (n = 0; n < 4; n = n + 1) begin
			wr(8'h10 + 8 * n, 32'hFFFF1D30 | n);
			wr(8'h14 + 8 * n, 32'hFF123400 + n);
		end
		for (n = 0; n < 4; n = n + 1) begin
			rd(8'h10 + 8 * n, 32'hFFFFFFFF, 32'h00FF1530 | n);
			rd(8'h14 + 8 * n, 32'hFFFFFFFF, 32'h00123400 + n);
		end
		rd(8'h00, 32'hFFFFFFFF, 32'h0);
		rd(8'h30, 32'hFFFFFFFF, 32'h0);
		rd(8'h11, 32'hFFFFFFFF, 32'h0);
		rd(8'h04, 32'h00000010, 32'h10);
		wr(8'h00, 32'h12);
		rd(8'h04, 32'h0001F000, 32'h00004000);
		for (n = 0; n < 4; n = n + 1)
			wr(8'h10 + 8 * n, 32'h0);
		wr(8'h00, 32'h25);
		wr(8'h00, 32'h23);
		rd(8'h04, 32'h00000F00, 32'h0);
		wr(8'h00, 32'h22);
		rd(8'h04, 32'h00000F00, 32'h00000A00);
		for (n = 0; n < 4; n = n + 1)
			rd(8'h10 + 8 * n, 32'hFFFFFFFF, 32'h00FF1530 | n);
		wr(8'h00, 32'h40);
		rd(8'h04, 32'h00000800, 32'h0);
		for (n = 0; n < 4; n = n + 1) begin
			rd(8'h10 + 8 * n, 32'hFFFFFFFF, 32'h0);
			rd(8'h14 + 8 * n, 32'hFFFFFFFF, 32'h0);
		end
		for (n = 0; n < 6; n = n + 1) begin
			wr(8'h10, (n << 8) | ((n & 3) << 4) | 1);
			rd(8'h10, 32'hFFFFFFFF, (n << 8) | ((n & 3) << 4) | 1);
		end
		wr(8'h10, 32'h4);
		repeat (100) @(posedge clk);
		mon <= 2'h1;
		repeat (60) @(posedge clk);
		mon <= 2'h0;
		// Blank all eight pairs, then reserve pairs 0 to 3 for data
		wr(8'h10, 32'h0);
		for (n = 0; n < 2; n = n + 1) begin
			wr(8'h14, n ? 32'h0FFF00 : 32'h00FF00);
			repeat (100) @(posedge clk);
			blk = 0;
			mon <= 2'h3;
			repeat (40) @(posedge clk);
			mon <= 2'h0;
			chk(blk, n ? 4 : 8);
		end
		wr(8'h10, 32'h200);
		repeat (50) @(posedge clk);
		run <= 4'hE;
		repeat (LOSS + 10) @(posedge clk);
		rd(8'h04, 32'h0000000F, 32'h1);
		repeat (10) @(posedge clk);
		mon <= 2'h2;
		repeat (40) @(posedge clk);
		mon <= 2'h0;
		run <= 4'hF;
		repeat (60) @(posedge clk);
		rd(8'h04, 32'h0000000F, 32'h0);
		summarize;
	end
endmodule
